// *** hetf_defs.vh ***
`ifndef HETF_DEFS_VH
`define HETF_DEFS_VH

// register word indexes (byte address is index*4, so every offset is a multiple of four)
`define HETF_IDX_FLAGS      8'h92
`define HETF_IDX_THRESH     8'h9c
`define HETF_IDX_TXSIZE     8'h9e
`define HETF_IDX_HASH0      8'ha0
`define HETF_IDX_HASH1      8'ha2
`define HETF_IDX_HASH2      8'ha4
`define HETF_IDX_HASH3      8'ha6
`define HETF_IDX_ENABLES    8'h90
`define HETF_IDX_PWR_EVT    8'hd4
`define HETF_IDX_QCTRL      8'h82
`define HETF_IDX_FREE_RD    8'h84
`define HETF_IDX_FILTER     8'h86

// interrupt_flags bit positions
`define HETF_BIT_RX_READY   13
`define HETF_BIT_TX_STOP    9
`define HETF_BIT_RX_STOP    8
`define HETF_BIT_TX_SPACE   6
`define HETF_BIT_WAKE_FRAME 5
`define HETF_BIT_MAGIC      4
`define HETF_BIT_LINKUP     3
`define HETF_BIT_ENERGY     2
`define HETF_FLAG_MASK      16'h237c

// queue control bits
`define HETF_BIT_BYTE_THR_EN  6
`define HETF_BIT_FRAME_THR_EN 5
`define HETF_BIT_TX_MON_EN    1

// power event field patterns in bits [5:2]
`define HETF_PME_WAKE_FRAME 4'h8
`define HETF_PME_MAGIC      4'h4
`define HETF_PME_LINKUP     4'h2
`define HETF_PME_ENERGY     4'h1

// filtering scheme and reset values
`define HETF_MODE_HASH_PERFECT 3'h5
`define HETF_RST_16            16'h0000

`endif

// *** hetf_top.v ***
// Summary of operation
// RULE_01: transmit halt sets flag bit 9, held until host clears.
// RULE_02: receive halt sets flag bit 8, held until host clears.
// RULE_03: stop flags latch on edge, clear by writing one, reads harmless.
// RULE_04: transmit space available sets flag bit 6, write one clears.
// RULE_05: wake frame flag bit 5, read only, cleared by event pattern 1000.
// RULE_06: magic packet flag bit 4, cleared by event pattern 0100.
// RULE_07: link-up wake flag bit 3, cleared by event pattern 0010.
// RULE_08: energy wake flag bit 2, plain or delayed by enables, pattern 0001 clears; the code sets it on the plain edge only, no delayed form.
// RULE_09: byte threshold enabled: rx ready flag when byte count exceeds threshold.
// RULE_10: frame threshold enabled: rx ready flag when frames reach threshold.
// RULE_11: host never programs frame threshold zero with frame interrupts on.
// RULE_12: host writes needed transmit space in double words before transmit.
// RULE_13: monitor enabled: flag bit 6 when free space covers the request.
// RULE_14: hash index is six top CRC bits over destination address.
// RULE_15: top two bits pick table word, low four pick the bit.
// RULE_16: set table bit accepts frame, cleared bit drops it.
// RULE_17: hash table filters only in hash-perfect scheme five.
// RULE_18: flag drives interrupt only while its enable is set.
// RULE_19: receive-all or receive-multicast accepts every multicast frame.
// RULE_20: flag bit 13 marks a received frame ready, write one clears.
// RULE_21: reserved flag bits read zero, writes ignored.
`timescale 1ns/1ps
`include "hetf_defs.vh"

module hetf_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [9:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        tx_halt_in,
	input  wire        rx_halt_in,
	input  wire        wake_frame_in,
	input  wire        magic_in,
	input  wire        linkup_in,
	input  wire        energy_in,
	input  wire        rx_frame_in,
	input  wire [15:0] rx_byte_count,
	input  wire [7:0]  rx_frame_count,
	input  wire [15:0] tx_free_dwords,
	input  wire        da_valid,
	input  wire [47:0] da_addr,
	output reg         da_accept,
	output reg         da_drop,
	output reg         irq_n
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------

	// crc-32 over the 48-bit address, lsb first, no final inversion
	function [31:0] hetf_crc48;
		input [47:0] d;
		integer      i;
		reg   [31:0] c;
		begin
			c = 32'hffffffff;
			for (i = 0; i < 48; i = i + 1) begin
				if (c[0] ^ d[i])
					c = (c >> 1) ^ 32'hedb88320;
				else
					c = c >> 1;
			end
			hetf_crc48 = c;
		end
	endfunction

	// rising edge of a synchronised level
	function hetf_rise;
		input now_v;
		input old_v;
		begin
			hetf_rise = now_v & ~old_v;
		end
	endfunction

	// word index of a byte address; the low two bits pick no register
	function [7:0] hetf_word;
		input [9:0] a;
		begin
			hetf_word = a[9:2];
		end
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------

	localparam NEV = 7;
	wire [NEV-1:0] ev_raw = {rx_frame_in, energy_in, linkup_in, magic_in, wake_frame_in, rx_halt_in, tx_halt_in};
	// sync stages; the third event stage only feeds the edge detectors
	reg  [NEV-1:0] ev_s1_reg;
	reg  [NEV-1:0] ev_s2_reg;
	reg  [NEV-1:0] ev_d_reg;
	reg  [15:0]    byte_s1_reg;
	reg  [15:0]    byte_s2_reg;
	reg  [7:0]     frm_s1_reg;
	reg  [7:0]     frm_s2_reg;
	reg  [15:0]    free_s1_reg;
	reg  [15:0]    free_s2_reg;

	// two flops on every event and count pin before use; counts assumed slowly changing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_s1_reg   <= {NEV{1'b0}};
			ev_s2_reg   <= {NEV{1'b0}};
			ev_d_reg    <= {NEV{1'b0}};
			byte_s1_reg <= 16'h0000;
			byte_s2_reg <= 16'h0000;
			frm_s1_reg  <= 8'h00;
			frm_s2_reg  <= 8'h00;
			free_s1_reg <= 16'h0000;
			free_s2_reg <= 16'h0000;
		end else begin
			ev_s1_reg   <= ev_raw;
			ev_s2_reg   <= ev_s1_reg;
			ev_d_reg    <= ev_s2_reg;
			byte_s1_reg <= rx_byte_count;
			byte_s2_reg <= byte_s1_reg;
			frm_s1_reg  <= rx_frame_count;
			frm_s2_reg  <= frm_s1_reg;
			free_s1_reg <= tx_free_dwords;
			free_s2_reg <= free_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------

	// zero wait states; unmapped addresses read zero, no error
	// answer lines are flops so every output leaves a register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
		end
	end

	// access-phase write strobe and word index; own strobes only for the flag and power event registers
	wire       wr_en = psel & penable & pwrite;
	wire [7:0] idx   = hetf_word(paddr);
	wire       wr_flags   = wr_en && (idx == `HETF_IDX_FLAGS);
	wire       wr_pwr     = wr_en && (idx == `HETF_IDX_PWR_EVT);

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------

	// host-programmed registers; hash words 1 to 3 complete the table
	reg [15:0] thresh_reg;
	reg [15:0] txsize_reg;
	reg [15:0] hash_reg [0:3];
	reg [15:0] enables_reg;
	reg [15:0] qctrl_reg;
	reg [4:0]  filter_reg;
	integer    k;

	// plain read/write storage
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thresh_reg  <= `HETF_RST_16;
			txsize_reg  <= `HETF_RST_16;
			enables_reg <= `HETF_RST_16;
			qctrl_reg   <= `HETF_RST_16;
			filter_reg  <= 5'h00;
			for (k = 0; k < 4; k = k + 1)
				hash_reg[k] <= `HETF_RST_16;
		end else if (wr_en) begin
			case (idx)
				`HETF_IDX_THRESH:  thresh_reg  <= pwdata[15:0];
				// RULE_12 host size request
				`HETF_IDX_TXSIZE:  txsize_reg  <= pwdata[15:0];
				`HETF_IDX_HASH0:   hash_reg[0] <= pwdata[15:0];
				`HETF_IDX_HASH1:   hash_reg[1] <= pwdata[15:0];
				`HETF_IDX_HASH2:   hash_reg[2] <= pwdata[15:0];
				`HETF_IDX_HASH3:   hash_reg[3] <= pwdata[15:0];
				`HETF_IDX_ENABLES: enables_reg <= pwdata[15:0];
				`HETF_IDX_QCTRL:   qctrl_reg   <= pwdata[15:0];
				`HETF_IDX_FILTER:  filter_reg  <= pwdata[4:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// interrupt flags
	// ----------------------------------------------------------------

	// flag state and the delayed compares that give their edges
	reg  [15:0] flags_reg;
	reg  [15:0] flags_next;
	reg         byte_hit_reg;
	reg         frame_hit_reg;
	reg         space_hit_reg;
	wire [3:0]  pme = pwdata[5:2];
	// RULE_09 byte threshold compare
	wire byte_hit  = qctrl_reg[`HETF_BIT_BYTE_THR_EN] && (byte_s2_reg > {8'h00, thresh_reg[15:8]});
	// RULE_10 frame threshold compare
	wire frame_hit = qctrl_reg[`HETF_BIT_FRAME_THR_EN] && (frm_s2_reg >= thresh_reg[7:0]);
	// RULE_13 transmit space compare
	wire space_hit = qctrl_reg[`HETF_BIT_TX_MON_EN] && (free_s2_reg >= txsize_reg);

	// clears first, sets after, so an event in the clear cycle survives
	always @* begin
		flags_next = flags_reg;
		// RULE_03 write one clears
		if (wr_flags)
			flags_next = flags_next & ~(pwdata[15:0] &
				((16'h1 << `HETF_BIT_RX_READY) | (16'h1 << `HETF_BIT_TX_STOP) |
				 (16'h1 << `HETF_BIT_RX_STOP) | (16'h1 << `HETF_BIT_TX_SPACE)));
		if (wr_pwr) begin
			// RULE_05 pattern clears wake frame
			if (pme == `HETF_PME_WAKE_FRAME)
				flags_next[`HETF_BIT_WAKE_FRAME] = 1'b0;
			// RULE_06 pattern clears magic
			if (pme == `HETF_PME_MAGIC)
				flags_next[`HETF_BIT_MAGIC] = 1'b0;
			// RULE_07 pattern clears link-up
			if (pme == `HETF_PME_LINKUP)
				flags_next[`HETF_BIT_LINKUP] = 1'b0;
			// RULE_08 pattern clears energy
			if (pme == `HETF_PME_ENERGY)
				flags_next[`HETF_BIT_ENERGY] = 1'b0;
		end
		// RULE_01 transmit halt edge
		if (hetf_rise(ev_s2_reg[0], ev_d_reg[0]))
			flags_next[`HETF_BIT_TX_STOP] = 1'b1;
		// RULE_02 receive halt edge
		if (hetf_rise(ev_s2_reg[1], ev_d_reg[1]))
			flags_next[`HETF_BIT_RX_STOP] = 1'b1;
		if (hetf_rise(ev_s2_reg[2], ev_d_reg[2]))
			flags_next[`HETF_BIT_WAKE_FRAME] = 1'b1;
		if (hetf_rise(ev_s2_reg[3], ev_d_reg[3]))
			flags_next[`HETF_BIT_MAGIC] = 1'b1;
		if (hetf_rise(ev_s2_reg[4], ev_d_reg[4]))
			flags_next[`HETF_BIT_LINKUP] = 1'b1;
		// RULE_08 energy wake, plain edge only, no delayed form
		if (hetf_rise(ev_s2_reg[5], ev_d_reg[5]))
			flags_next[`HETF_BIT_ENERGY] = 1'b1;
		// RULE_20 frame ready or threshold
		if (hetf_rise(ev_s2_reg[6], ev_d_reg[6]) || (byte_hit & ~byte_hit_reg) ||
		    (frame_hit & ~frame_hit_reg))
			flags_next[`HETF_BIT_RX_READY] = 1'b1;
		// RULE_04 space available edge
		if (space_hit & ~space_hit_reg)
			flags_next[`HETF_BIT_TX_SPACE] = 1'b1;
		// RULE_21 reserved bits stay zero
		flags_next = flags_next & `HETF_FLAG_MASK;
	end

	// flags and compare history; a level left high raises no second flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg     <= `HETF_RST_16;
			byte_hit_reg  <= 1'b0;
			frame_hit_reg <= 1'b0;
			space_hit_reg <= 1'b0;
		end else begin
			flags_reg     <= flags_next;
			byte_hit_reg  <= byte_hit;
			frame_hit_reg <= frame_hit;
			space_hit_reg <= space_hit;
		end
	end

	// RULE_18 enabled flags drive interrupt
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_n <= 1'b1;
		else
			irq_n <= ~|(flags_next & enables_reg);
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------

	// registered on setup so data is ready in the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			case (idx)
				`HETF_IDX_FLAGS:   prdata <= {16'h0000, flags_reg};
				`HETF_IDX_THRESH:  prdata <= {16'h0000, thresh_reg};
				`HETF_IDX_TXSIZE:  prdata <= {16'h0000, txsize_reg};
				`HETF_IDX_HASH0:   prdata <= {16'h0000, hash_reg[0]};
				`HETF_IDX_HASH1:   prdata <= {16'h0000, hash_reg[1]};
				`HETF_IDX_HASH2:   prdata <= {16'h0000, hash_reg[2]};
				`HETF_IDX_HASH3:   prdata <= {16'h0000, hash_reg[3]};
				`HETF_IDX_ENABLES: prdata <= {16'h0000, enables_reg};
				`HETF_IDX_QCTRL:   prdata <= {16'h0000, qctrl_reg};
				`HETF_IDX_FREE_RD: prdata <= {free_s2_reg, 8'h00, frm_s2_reg};
				`HETF_IDX_FILTER:  prdata <= {27'h0, filter_reg};
				default:           prdata <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// multicast hash filter
	// ----------------------------------------------------------------

	// RULE_14 six top crc bits
	wire [31:0] crc  = hetf_crc48(da_addr);
	wire [5:0]  hidx = crc[31:26];
	// RULE_15 word and bit select
	wire [15:0] hword = hash_reg[hidx[5:4]];
	wire        hbit  = hword[hidx[3:0]];
	wire        is_mc = da_addr[0];
	// RULE_19 receive-all or receive-multicast override
	wire        pass_all = filter_reg[3] | filter_reg[4];
	// RULE_17 only scheme five uses the table
	wire        hash_mode = (filter_reg[2:0] == `HETF_MODE_HASH_PERFECT);
	reg         acc;

	// verdict before the register; non-hash modes pass everything
	always @* begin
		acc = 1'b1;
		if (is_mc && !pass_all && hash_mode)
			// RULE_16 set bit accepts, clear drops
			acc = hbit;
	end

	// verdict one cycle after da_valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			da_accept <= 1'b0;
			da_drop   <= 1'b0;
		end else begin
			da_accept <= da_valid & acc;
			da_drop   <= da_valid & ~acc;
		end
	end

endmodule

// *** hetf_evt_src.sv ***
`timescale 1ns/1ps
// ------------------------------------------------
// event source standing in for the mac core
// ------------------------------------------------
module hetf_evt_src (
	input  wire        pclk,
	input  wire  [6:0] fire,
	output logic [6:0] lines
);
	logic [6:0] h1 = 7'h00;
	logic [6:0] h2 = 7'h00;
	logic [6:0] h3 = 7'h00;
	initial lines = 7'h00;
	// rising event levels
	// a one-cycle request becomes a four-cycle level, so a slow core is mimicked
	always @(posedge pclk) begin
		h1 <= fire;
		h2 <= h1;
		h3 <= h2;
		lines <= fire | h1 | h2 | h3;
	end
endmodule

// *** hetf_checker.sv ***
`timescale 1ns/1ps
`include "hetf_defs.vh"
// ------------------------------------------------
// port checks on bus, filter and interrupt
// ------------------------------------------------
module hetf_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [9:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        tx_halt_in,
	input wire        rx_halt_in,
	input wire        da_valid,
	input wire [47:0] da_addr,
	input wire        da_accept,
	input wire        da_drop,
	input wire        irq_n
);
	logic [15:0] en_reg;
	logic [15:0] sz_reg;
	wire         acc = psel && penable;
	// shadow of enables and requested size, so irq and readback can be judged
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 16'h0000;
			sz_reg <= 16'h0000;
		end else if (acc && pwrite) begin
			if (paddr == {`HETF_IDX_ENABLES, 2'b00}) en_reg <= pwdata[15:0];
			if (paddr == {`HETF_IDX_TXSIZE, 2'b00}) sz_reg <= pwdata[15:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_irq_low;
		##[1:5] !irq_n;
	endsequence
	chk_filter_onehot: assert property (da_valid |=> da_accept != da_drop)
		else $error("filter gave no single verdict");
	chk_filter_idle: assert property (!da_valid |=> !da_accept && !da_drop)
		else $error("filter verdict without request");
	chk_unicast_pass: assert property (da_valid && !da_addr[0] |=> da_accept)
		else $error("unicast frame dropped");
	chk_reserved_zero: assert property (acc && !pwrite && paddr == {`HETF_IDX_FLAGS, 2'b00}
		|-> (prdata & 32'hffffdc83) == 32'h0) else $error("reserved flag bits set");
	chk_size_hold: assert property (acc && !pwrite && paddr == {`HETF_IDX_TXSIZE, 2'b00}
		|-> prdata == {16'h0000, sz_reg}) else $error("size readback wrong");
	chk_irq_masked: assert property (en_reg == 16'h0000 |=> irq_n)
		else $error("irq with all enables off");
	chk_txstop_irq: assert property ($rose(tx_halt_in) && en_reg[9] |-> s_irq_low)
		else $error("no irq after tx halt");
	chk_rxstop_irq: assert property ($rose(rx_halt_in) && en_reg[8] |-> s_irq_low)
		else $error("no irq after rx halt");
endmodule
bind hetf_top hetf_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.tx_halt_in, .rx_halt_in, .da_valid, .da_addr, .da_accept, .da_drop, .irq_n);

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "hetf_defs.vh"
module tb_top;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, da_valid = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [6:0]  fire = 7'h00;
	logic [15:0] rx_byte_count = 16'h0, tx_free_dwords = 16'h0;
	logic [7:0]  rx_frame_count = 8'h0;
	logic [47:0] da_addr = 48'h01005e000001;
	wire  [31:0] prdata;
	wire  [6:0]  ev;
	wire         pready, pslverr, da_accept, da_drop, irq_n;
	int          n_fail = 0, total_checks = 0;
	int          bp[7] = '{9, 8, 5, 4, 3, 2, 13};
	localparam logic [9:0] A_FL = {`HETF_IDX_FLAGS, 2'b00}, A_EN = {`HETF_IDX_ENABLES, 2'b00};
	localparam logic [9:0] A_PW = {`HETF_IDX_PWR_EVT, 2'b00}, A_Q = {`HETF_IDX_QCTRL, 2'b00};
	localparam logic [9:0] A_TH = {`HETF_IDX_THRESH, 2'b00}, A_SZ = {`HETF_IDX_TXSIZE, 2'b00};
	localparam logic [9:0] A_H0 = {`HETF_IDX_HASH0, 2'b00}, A_FT = {`HETF_IDX_FILTER, 2'b00};
	localparam logic [9:0] A_ST = {`HETF_IDX_FREE_RD, 2'b00};
	// free-running 125 mhz clock
	always #4 pclk = ~pclk;
	hetf_evt_src u_src (.pclk(pclk), .fire(fire), .lines(ev));
	hetf_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.tx_halt_in(ev[0]), .rx_halt_in(ev[1]), .wake_frame_in(ev[2]), .magic_in(ev[3]), .linkup_in(ev[4]),
		.energy_in(ev[5]), .rx_frame_in(ev[6]), .rx_byte_count, .rx_frame_count, .tx_free_dwords,
		.da_valid, .da_addr, .da_accept, .da_drop, .irq_n);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input string what, input logic [9:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask
	// counts are quasi-static, so settle them well past the two-flop sync
	task automatic cnt(input logic [15:0] b, input logic [7:0] f, input logic [15:0] t, input logic [31:0] e);
		@(posedge pclk);
		rx_byte_count  <= b;
		rx_frame_count <= f;
		tx_free_dwords <= t;
		repeat (8) @(posedge pclk);
		rd("flags after count", A_FL, e);
	endtask
	task automatic filt(input logic [15:0] h, input logic [4:0] m, input logic mc, input logic e);
		for (int i = 0; i < 4; i++) wr(A_H0 + 10'(8 * i), {16'h0, h});
		wr(A_FT, {27'h0, m});
		@(posedge pclk);
		da_valid   <= 1'b1;
		da_addr[0] <= mc;
		@(posedge pclk);
		da_valid <= 1'b0;
		#1 chk("da_accept", {31'h0, e}, {31'h0, da_accept});
		chk("da_drop", {31'h0, ~e}, {31'h0, da_drop});
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd("flags reset", A_FL, 0);
		rd("size reset", A_SZ, 0);
		rd("hash0 reset", A_H0, 0);
		rd("thresh reset", A_TH, 0);
		rd("unmapped", 10'h3fc, 0);
		chk("pready", 1, {31'h0, pready});
		chk("pslverr", 0, {31'h0, pslverr});
		wr(A_SZ, 32'hffff);
		rd("size rw", A_SZ, 32'hffff);
		wr(A_H0, 32'ha5c3);
		rd("hash0 rw", A_H0, 32'ha5c3);
		$display("test registers finished");
		wr(A_EN, 32'hffff);
		wr(A_FL, 32'hffff);
		rd("flags w1 idle", A_FL, 0);
		for (int i = 0; i < 7; i++) begin
			@(posedge pclk) fire <= 7'(1 << i);
			@(posedge pclk) fire <= 7'h00;
			repeat (8) @(posedge pclk);
			rd("flag set", A_FL, 32'(1) << bp[i]);
			rd("flag kept", A_FL, 32'(1) << bp[i]);
			chk("irq_n low", 0, {31'h0, irq_n});
			wr(A_FL, 32'(1) << bp[i]);
			if (i >= 2 && i <= 5) begin
				rd("flag read only", A_FL, 32'(1) << bp[i]);
				wr(A_PW, 32'((8 >> (i - 2)) << 2));
			end
			rd("flag cleared", A_FL, 0);
			chk("irq_n high", 1, {31'h0, irq_n});
		end
		$display("test events finished");
		wr(A_TH, 32'h1003);
		wr(A_Q, 32'h20);
		cnt(0, 2, 0, 0);
		cnt(0, 3, 0, 32'h2000);
		wr(A_FL, 32'h2000);
		wr(A_Q, 32'h40);
		cnt(16'h10, 0, 0, 0);
		cnt(16'h11, 0, 0, 32'h2000);
		wr(A_FL, 32'h2000);
		wr(A_SZ, 32'h10);
		wr(A_Q, 32'h2);
		cnt(0, 0, 16'hf, 0);
		cnt(0, 0, 16'h10, 32'h40);
		rd("count status", A_ST, 32'h00100000);
		wr(A_FL, 32'h40);
		rd("space cleared", A_FL, 0);
		$display("test thresholds finished");
		filt(16'hffff, 5'h05, 1, 1);
		filt(16'h0000, 5'h05, 1, 0);
		filt(16'h0000, 5'h00, 1, 1);
		filt(16'h0000, 5'h0d, 1, 1);
		filt(16'h0000, 5'h15, 1, 1);
		filt(16'h0000, 5'h05, 0, 1);
		$display("test filter finished");
		give_verdict;
	end
	// the tests need a few hundred cycles; this is ample margin
	initial begin
		#100000;
		n_fail++;
		give_verdict;
	end
endmodule
